//--- dram_port_pkg.sv
package dram_port_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int INIT_TIME_NS = 2000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_LAT_CYCLES = 4;

    localparam int QUEUE_DEPTH = 8;
    localparam int QPTR_W = 3;
    localparam int QCNT_W = 4;

    localparam int MEM_BYTES = 4096;
    localparam int MEM_WORDS = MEM_BYTES / 8;
    localparam int WIDX_W = 9;
    localparam logic [31:0] ADDR_LIMIT = 32'(MEM_BYTES / 2);
    localparam int ADDR_STEP = 4;

    localparam logic [7:0] CMD_WRITE = 8'h00;
    localparam logic [7:0] CMD_READ = 8'h01;

    localparam int AXI_ADDR_W = 12;
    localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [AXI_ADDR_W-1:0] REG_DROPS = 12'h008;
    localparam int CTRL_INIT_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_LEVEL_LSB = 8;
    localparam logic [15:0] DROPS_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ENG_INIT, ENG_IDLE, ENG_READ} eng_state_t;

endpackage

//--- dram_port_64.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Functional notes
// RULE_01 - Read result appears as high and low 32-bit halves, valid with the pulse.
// RULE_02 - A read takes several cycles, then read-valid pulses for one cycle.
// RULE_03 - Requester must capture read data in the pulse cycle itself.
// RULE_04 - Write data halves are taken only in a command-issue cycle.
// RULE_05 - Accepted commands enter a queue; queue-full is high when no entry is free.
// RULE_06 - Requester must not issue while queue-full is high.
// RULE_07 - Initialization runs after reset and again on a host interface reset.
// RULE_08 - Init-done is low during initialization and high once it finishes.
// RULE_09 - Requester must not issue commands before init-done.
// RULE_10 - Address counts 16-bit units; consecutive 64-bit accesses step by 4.
// RULE_11 - Valid addresses lie below memory bytes divided by 2.
// RULE_12 - All port signals share one user clock with the requester.
// RULE_13 - No synchronizer stages on port signals; zero added latency.
// RULE_14 - Several reads may be outstanding; results return in request order.
// RULE_15 - Read: check full, drive address, code 1, pulse command-issue.
// RULE_16 - Write: check full, drive address and data, code 0, pulse issue.
// RULE_17 - Each cycle with command-issue high is a separate new command.
// RULE_18 - Address and code are sampled only in a command-issue cycle.
// RULE_19 - Address is 32-bit unsigned, code 8-bit with only write and read defined.
// RULE_20 - Commands issued when full or before init-done are dropped.
// RULE_21 - Undefined command codes are no-ops and never queued.
module dram_port_64
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dram_port_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dram_port_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] cmd_addr,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_issue,
    input wire logic [31:0] wr_data_hi,
    input wire logic [31:0] wr_data_lo,
    output logic queue_full,
    output logic [31:0] rd_data_hi,
    output logic [31:0] rd_data_lo,
    output logic rd_valid,
    output logic init_done
);
    import dram_port_pkg::*;

    function automatic logic addr_ok(input logic [31:0] a);
        return a < ADDR_LIMIT;
    endfunction
    function automatic logic [WIDX_W-1:0] word_index(input logic [31:0] a);
        return a[WIDX_W+1:2];
    endfunction

    // Port signals are used directly: any extra stage would add latency. [RULE_12] [RULE_13]
    logic [31:0] q_addr [QUEUE_DEPTH];
    logic q_is_read [QUEUE_DEPTH];
    logic [63:0] q_wdata [QUEUE_DEPTH];
    logic [63:0] mem [MEM_WORDS];

    logic [QPTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [QCNT_W-1:0] count_q, count_d;
    eng_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic [63:0] rbuf_q, rbuf_d, rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d, init_done_q, init_done_d;
    logic [15:0] drops_q, drops_d;
    logic init_req, code_ok, push, pop, pop_read, drop, wr_fire;
    logic [31:0] head_addr;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [AXI_ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    assign queue_full = (count_q == QCNT_W'(QUEUE_DEPTH)); // [RULE_05]
    assign code_ok = (cmd_code == CMD_WRITE) || (cmd_code == CMD_READ); // [RULE_19]
    // Issue is accepted only when ready; anything else is discarded and counted, the count saturating at 16'hFFFF.
    assign push = cmd_issue && code_ok && !queue_full && init_done_q; // [RULE_17] [RULE_20] [RULE_21]
    assign drop = cmd_issue && !push;
    assign pop = (state_q == ENG_IDLE) && (count_q != '0) && !init_req;
    assign pop_read = pop && q_is_read[rd_ptr_q];
    assign head_addr = q_addr[rd_ptr_q];

    // Queue storage: address, code and data are captured only on a push. [RULE_04] [RULE_18]
    always_ff @(posedge aclk)
        if (push)
        begin
            q_addr[wr_ptr_q] <= cmd_addr;
            q_is_read[wr_ptr_q] <= (cmd_code == CMD_READ);
            q_wdata[wr_ptr_q] <= {wr_data_hi, wr_data_lo};
        end
    // Each entry moves 64 bits over four 16-bit address units. [RULE_10] [RULE_11]
    always_ff @(posedge aclk)
        if (pop && !q_is_read[rd_ptr_q] && addr_ok(head_addr))
            mem[word_index(head_addr)] <= q_wdata[rd_ptr_q];
    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (init_req)
        begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            count_d = '0;
        end
        else
        begin
            if (push)
                wr_ptr_d = wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_d = rd_ptr_q + 1'b1;
            count_d = count_q + QCNT_W'(push) - QCNT_W'(pop); // [RULE_05]
        end
    end

    // One entry is served at a time, so results leave in request order. [RULE_14]
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        rbuf_d = rbuf_q;
        rd_valid_d = 1'b0;
        rd_data_d = '0;
        if (init_req)
        begin
            state_d = ENG_INIT; // [RULE_07]
            cnt_d = 8'(INIT_CYCLES - 1);
        end
        else
        begin
            case (state_q)
                ENG_INIT:
                    if (cnt_q == '0)
                        state_d = ENG_IDLE;
                    else
                        cnt_d = cnt_q - 1'b1;
                ENG_IDLE:
                    if (pop_read)
                    begin
                        state_d = ENG_READ;
                        cnt_d = 8'(READ_LAT_CYCLES - 1);
                        rbuf_d = addr_ok(head_addr) ? mem[word_index(head_addr)] : '0;
                    end
                ENG_READ:
                    if (cnt_q == '0)
                    begin
                        state_d = ENG_IDLE;
                        rd_valid_d = 1'b1; // [RULE_02]
                        rd_data_d = rbuf_q; // [RULE_01]
                    end
                    else
                        cnt_d = cnt_q - 1'b1;
                default:
                begin
                    state_d = ENG_INIT;
                    cnt_d = 8'(INIT_CYCLES - 1);
                end
            endcase
        end
        init_done_d = (state_d != ENG_INIT); // [RULE_08]
        // A drop in the same cycle as a software clear still counts.
        drops_d = (wr_fire && aw_addr_q == REG_DROPS && w_strb_q[0]) ? DROPS_RESET : drops_q;
        if (drop && drops_d != 16'hFFFF)
            drops_d = drops_d + 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            state_q <= ENG_INIT; // [RULE_07]
            cnt_q <= 8'(INIT_CYCLES - 1);
            rbuf_q <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
            init_done_q <= 1'b0;
            drops_q <= DROPS_RESET;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            rbuf_q <= rbuf_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            init_done_q <= init_done_d;
            drops_q <= drops_d;
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data_hi = rd_data_q[63:32];
    assign rd_data_lo = rd_data_q[31:0];
    assign init_done = init_done_q;
    // Register slave: address and data may arrive in either order.
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign init_req = wr_fire && (aw_addr_q == REG_CTRL) && w_strb_q[0]
        && w_data_q[CTRL_INIT_BIT];
    always_comb
    begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (aw_addr_q == REG_CTRL || aw_addr_q == REG_STATUS
                || aw_addr_q == REG_DROPS) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = '0;
            case (s_axi_araddr)
                REG_CTRL: rdata_d = '0;
                REG_STATUS:
                begin
                    rdata_d[STAT_DONE_BIT] = init_done_q;
                    rdata_d[STAT_FULL_BIT] = queue_full;
                    rdata_d[STAT_LEVEL_LSB +: QCNT_W] = count_q;
                end
                REG_DROPS: rdata_d = {16'h0000, drops_q};
                default: rresp_d = RESP_SLVERR;
            endcase
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PULSE_ONE: assert property (rd_valid |=> !rd_valid) // [RULE_02]
        else $error("read valid longer than one cycle");
    AST_READ_LAT: assert property (pop_read ##1 (state_q == ENG_READ)[*4] |=> rd_valid) // [RULE_02]
        else $error("read result not delivered after fixed latency");
    AST_DATA_QUIET: assert property (!rd_valid |-> rd_data_hi == '0 && rd_data_lo == '0) // [RULE_01]
        else $error("read data changes outside the valid pulse");
    AST_FULL_SET: assert property (push && !pop && count_q == 4'h7 && !init_req |=> queue_full) // [RULE_05]
        else $error("queue full not raised on last free entry");
    AST_DROP_FULL: assert property (queue_full && !pop && !init_req |=> $stable(count_q)) // [RULE_20]
        else $error("command accepted while queue full");
    AST_NOP_CODE: assert property (cmd_issue && !code_ok |-> !push) // [RULE_21]
        else $error("undefined code entered the queue");
    AST_EACH_CYCLE: assert property (push && !pop && !init_req |=> count_q == $past(count_q) + 1'b1) // [RULE_17]
        else $error("issue cycle not counted as one command");
    AST_WDATA_TAKEN: assert property (push |=> q_wdata[$past(wr_ptr_q)] == $past({wr_data_hi, wr_data_lo})) // [RULE_04]
        else $error("write data not captured on issue");
    AST_ADDR_TAKEN: assert property (push |=> q_addr[$past(wr_ptr_q)] == $past(cmd_addr)) // [RULE_18]
        else $error("address not captured on issue");
    AST_INIT_LOW: assert property (init_req |=> !init_done[*8]) // [RULE_08]
        else $error("init done high during initialization");
    AST_INIT_END: assert property (state_q == ENG_INIT && cnt_q == '0 && !init_req |=> init_done) // [RULE_07]
        else $error("init done not raised at end of sequence");
    COV_READ: cover property (pop_read ##[1:8] rd_valid);
    COV_FULL: cover property (queue_full);
    COV_REINIT: cover property (init_done ##1 init_req ##[1:100] init_done);
    COV_TWO_READS: cover property (rd_valid ##[1:10] rd_valid);
endmodule // dram_port_64

//--- requester_model.sv
`timescale 1ns/100ps
module requester_model
(
    input wire logic aclk,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data_hi,
    input wire logic [31:0] rd_data_lo,
    output logic [31:0] cmd_addr,
    output logic [7:0] cmd_code,
    output logic cmd_issue,
    output logic [31:0] wr_data_hi,
    output logic [31:0] wr_data_lo
);
    int cyc = 0;
    int stamps[$];
    logic [63:0] got[$];
    initial
    begin
        {cmd_addr, cmd_code, cmd_issue} = 41'h0;
        {wr_data_hi, wr_data_lo} = 64'h0;
    end
    // Read halves are kept only at the pulse edge, since later values are not trusted.
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (rd_valid === 1'b1)
        begin
            got.push_back({rd_data_hi, rd_data_lo});
            stamps.push_back(cyc + 1);
        end
    end
    // The caller keeps issue high across calls; t is the edge that takes the command.
    task automatic issue(input logic [7:0] c, input logic [31:0] a, input logic [63:0] d,
                         output int t);
        @(posedge aclk);
        t = cyc + 2;
        cmd_code <= c;
        cmd_addr <= a;
        {wr_data_hi, wr_data_lo} <= d;
        cmd_issue <= 1'b1;
    endtask
    // Released lines show the inverse so that stale values cannot pass for held ones.
    task automatic idle();
        @(posedge aclk);
        cmd_issue <= 1'b0;
        cmd_addr <= ~cmd_addr;
        cmd_code <= ~cmd_code;
        {wr_data_hi, wr_data_lo} <= ~{wr_data_hi, wr_data_lo};
    endtask
endmodule // requester_model

//--- test_random_access_dram_port_64.sv
`timescale 1ns/100ps
module test_random_access_dram_port_64;
    import dram_port_pkg::*;
    logic aclk, aresetn;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] cmd_addr, wr_data_hi, wr_data_lo, rd_data_hi, rd_data_lo, rd;
    logic [7:0] cmd_code;
    logic cmd_issue, queue_full, rd_valid, init_done;
    int failures = 0;
    int comparisons = 0;
    dram_port_64 u_dram_port_64 (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cmd_addr, .cmd_code, .cmd_issue, .wr_data_hi, .wr_data_lo,
        .queue_full, .rd_data_hi, .rd_data_lo, .rd_valid, .init_done);
    requester_model u_requester_model (.aclk, .rd_valid, .rd_data_hi, .rd_data_lo, .cmd_addr,
        .cmd_code, .cmd_issue, .wr_data_hi, .wr_data_lo);
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    function automatic logic [63:0] pat(input int k);
        return 64'hC0DE_0000_5A00_0000 + 64'(k) * 64'h0000_0001_0000_0001;
    endfunction
    task automatic close_out();
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tmo();
        failures++;
        close_out();
    endtask
    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d);
        logic aw = 1'b1;
        logic w = 1'b1;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (!aw && !w && s_axi_bvalid === 1'b1)
                break;
            aw = aw && s_axi_awready !== 1'b1;
            w = w && s_axi_wready !== 1'b1;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50)
            tmo();
    endtask
    task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1)
                break;
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50)
            tmo();
    endtask
    task automatic wait_init(output int n);
        for (n = 1; n < 300 && init_done !== 1'b1; n++)
            @(posedge aclk);
        if (n == 300)
            tmo();
    endtask
    task automatic wait_got(input int k);
        int n;
        for (n = 0; n < 300 && u_requester_model.got.size() < k; n++)
            @(posedge aclk);
        if (n == 300)
            tmo();
        u_requester_model.got.delete();
        u_requester_model.stamps.delete();
    endtask
    task automatic t_init();
        int n;
        cmp("full_in_init", 0, queue_full);
        wait_init(n);
        cmp("init_len", 1, n >= 80 && n <= 82);
    endtask
    task automatic t_rw();
        int t;
        int t0;
        cmp("free_at_issue", 0, queue_full);
        for (int k = 0; k < 12; k++)
            u_requester_model.issue(CMD_WRITE, 32'h100 + 32'(ADDR_STEP * k), pat(k), t);
        u_requester_model.idle();
        repeat (20) @(posedge aclk);
        u_requester_model.issue(CMD_READ, 32'h0000_0100, 64'h0, t0);
        for (int k = 1; k < 4; k++)
            u_requester_model.issue(CMD_READ, 32'h100 + 32'(ADDR_STEP * k), 64'h0, t);
        u_requester_model.idle();
        repeat (30) @(posedge aclk);
        cmp("rd_lat", 6, u_requester_model.stamps[0] - t0);
        cmp("rd_count", 4, u_requester_model.got.size());
        for (int k = 0; k < 4; k++)
            cmp("rd_word", pat(k), u_requester_model.got[k]);
        wait_got(4);
    endtask
    task automatic t_odd();
        int t;
        axi_wr(REG_DROPS, 32'h0000_0000);
        cmp("bresp", RESP_OKAY, rsp);
        u_requester_model.issue(8'h02, 32'h0000_0100, 64'h0, t);
        u_requester_model.issue(CMD_WRITE, ADDR_LIMIT, 64'hFFFF_0000_FFFF_0000, t);
        u_requester_model.issue(CMD_READ, 32'h0000_0100, 64'h0, t);
        u_requester_model.issue(CMD_READ, ADDR_LIMIT, 64'h0, t);
        u_requester_model.idle();
        repeat (30) @(posedge aclk);
        cmp("noop_word", pat(0), u_requester_model.got[0]);
        cmp("limit_word", 0, u_requester_model.got[1]);
        wait_got(2);
        axi_rd(REG_DROPS);
        cmp("drops", 1, rd);
    endtask
    task automatic t_restart();
        int n;
        int t;
        axi_wr(REG_CTRL, 32'h0000_0001);
        for (n = 0; n < 10 && init_done === 1'b1; n++)
            @(posedge aclk);
        cmp("init_low", 0, init_done);
        u_requester_model.issue(CMD_WRITE, 32'h0000_0100, 64'h0, t);
        u_requester_model.idle();
        wait_init(n);
        u_requester_model.issue(CMD_READ, 32'h0000_0100, 64'h0, t);
        u_requester_model.idle();
        repeat (10) @(posedge aclk);
        cmp("early_dropped", pat(0), u_requester_model.got[0]);
        wait_got(1);
    endtask
    task automatic t_fill();
        int t;
        int j = 0;
        logic seen = 1'b0;
        axi_wr(REG_DROPS, 32'h0000_0000);
        for (int k = 0; k < 12; k++)
        begin
            u_requester_model.issue(CMD_READ, 32'h100 + 32'(ADDR_STEP * k), 64'h0, t);
            seen = seen | (queue_full === 1'b1);
        end
        u_requester_model.idle();
        repeat (80) @(posedge aclk);
        cmp("full_seen", 1, seen);
        cmp("drained_full", 0, queue_full);
        cmp("fill_kept", 1, u_requester_model.got.size() > QUEUE_DEPTH);
        foreach (u_requester_model.got[i])
        begin
            while (j < 12 && pat(j) !== u_requester_model.got[i])
                j++;
            j++;
        end
        cmp("rd_order", 1, j <= 12);
        axi_rd(REG_DROPS);
        cmp("fill_total", 12, u_requester_model.got.size() + rd);
        wait_got(0);
        axi_rd(REG_STATUS);
        cmp("status", 32'h0000_0001, rd);
        axi_rd(12'h00C);
        cmp("unmapped", {RESP_SLVERR, 32'h0000_0000}, {rsp, rd});
        axi_wr(12'h00C, 32'h0000_0001);
        cmp("unmapped_wr", RESP_SLVERR, rsp);
    endtask
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_init();
        t_rw();
        t_odd();
        t_restart();
        t_fill();
        close_out();
    end
endmodule // test_random_access_dram_port_64
